//--- pkg/fddi_pkg.sv
package fddi_pkg;
   // register map, byte addresses
   localparam logic [3:0] FDDI_ADDR_CTRL = 4'h0;
   localparam logic [3:0] FDDI_ADDR_STAT = 4'h4;
   // control field positions
   localparam int FDDI_CTRL_HL_IFACE = 0;
   localparam int FDDI_CTRL_HL_SEL = 1;
   localparam int FDDI_CTRL_HL_MOTOR = 2;
   localparam int FDDI_CTRL_DOOR_LO = 3;
   localparam int FDDI_CTRL_LOCK_FIT = 5;
   localparam int FDDI_CTRL_W = 6;
   localparam logic [5:0] FDDI_CTRL_RST = 6'h00;
   // door lock strap modes
   typedef enum logic [1:0] {
      FDDI_DOOR_IFACE = 2'h0,
      FDDI_DOOR_IFSEL = 2'h1,
      FDDI_DOOR_LATCH = 2'h2
   } fddi_door_e;
   // motor state, gray along off -> on -> hold
   typedef enum logic [1:0] {
      FDDI_MOT_OFF = 2'h0,
      FDDI_MOT_ON = 2'h1,
      FDDI_MOT_HOLD = 2'h3
   } fddi_mot_e;
   // timing
   localparam int FDDI_CLK_MHZ = 100;
   localparam int FDDI_TICK_US = 100;
   localparam int FDDI_TICK_CYC = FDDI_TICK_US * FDDI_CLK_MHZ;
   localparam int FDDI_MOTOR_S = 60;
   localparam int FDDI_MOTOR_TICKS = FDDI_MOTOR_S * 1000000 / FDDI_TICK_US;
   localparam int FDDI_INDEX_US = 3500;
   localparam int FDDI_INDEX_TICKS = FDDI_INDEX_US / FDDI_TICK_US;
   localparam int FDDI_READ_NS = 1000;
   localparam int FDDI_READ_CYC = FDDI_READ_NS * FDDI_CLK_MHZ / 1000;
   // interface lines from the controller, logic-true polarity except door_unlock_n and in_use_n, which are active low
   typedef struct packed {
      logic unit_sel;
      logic motor_on;
      logic head_load;
      logic write_gate;
      logic write_data;
      logic door_unlock_n;
      logic in_use_n;
   } fddi_host_s;
   // drive-internal sensors
   typedef struct packed {
      logic power_ok;
      logic door_closed;
      logic speed_ok;
      logic cyl_zero;
      logic phase_a;
      logic index_hole;
      logic notch_covered;
      logic disk_present;
      logic flux_detect;
   } fddi_sense_s;
   // status lines toward the controller
   typedef struct packed {
      logic ready;
      logic track_zero_status;
      logic index;
      logic read_data;
      logic write_protect;
      logic disk_change;
   } fddi_stat_s;
   // drive-internal actuators
   typedef struct packed {
      logic motor_run;
      logic head_load;
      logic write_en;
      logic erase_en;
      logic read_en;
      logic flux_write;
      logic front_led;
      logic unlock_sol;
      logic lock_engage;
   } fddi_act_s;
endpackage

//--- hdl/fddi_drive.sv
`timescale 1ns/10ps
module fddi_drive #(
   parameter int TICK_CYC = fddi_pkg::FDDI_TICK_CYC,
   parameter int MOTOR_TICKS = fddi_pkg::FDDI_MOTOR_TICKS,
   parameter int INDEX_TICKS = fddi_pkg::FDDI_INDEX_TICKS,
   parameter int READ_CYC = fddi_pkg::FDDI_READ_CYC
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire fddi_pkg::fddi_host_s host_in,
   input wire fddi_pkg::fddi_sense_s sense_in,
   output fddi_pkg::fddi_stat_s stat_out,
   output fddi_pkg::fddi_act_s act_out,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   import fddi_pkg::*;

   localparam int TW = $clog2(TICK_CYC + 1);
   localparam int MW = $clog2(MOTOR_TICKS + 1);
   localparam int IW = $clog2(INDEX_TICKS + 1);
   localparam int RW = $clog2(READ_CYC + 1);

   function automatic logic rise(input logic now, input logic was);
      rise = now & ~was;
   endfunction

   // two-stage synchronisers; the first stage feeds only the second
   fddi_host_s host_m_q, host_s_q, host_p_q;
   fddi_sense_s sense_m_q, sense_s_q, sense_p_q;
   always_ff @(posedge clk_sys) begin
      host_m_q <= host_in;
      host_s_q <= host_m_q;
      host_p_q <= host_s_q;
      sense_m_q <= sense_in;
      sense_s_q <= sense_m_q;
      sense_p_q <= sense_s_q;
   end

   logic sel;
   logic sel_rise;
   logic sel_fall;
   assign sel = host_s_q.unit_sel;
   assign sel_rise = rise(host_s_q.unit_sel, host_p_q.unit_sel);
   assign sel_fall = rise(host_p_q.unit_sel, host_s_q.unit_sel);

   // register port: control straps and status readback
   logic [FDDI_CTRL_W-1:0] ctrl_q;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ctrl_q <= FDDI_CTRL_RST;
      end else if (reg_wr && reg_addr == FDDI_ADDR_CTRL) begin
         ctrl_q <= reg_wdata[FDDI_CTRL_W-1:0];
      end
   end

   fddi_door_e door_mode;
   assign door_mode = fddi_door_e'(ctrl_q[FDDI_CTRL_DOOR_LO +: 2]);

   // slow time base: one pulse per tick period
   logic [TW-1:0] tick_cnt_q;
   logic tick_q;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == TW'(TICK_CYC - 1)) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   // motor: each new motor-on restarts the full run period
   fddi_mot_e mot_q;
   logic [MW-1:0] mot_cnt_q;
   logic mot_rise;
   assign mot_rise = rise(host_s_q.motor_on, host_p_q.motor_on);
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mot_q <= FDDI_MOT_OFF;
         mot_cnt_q <= '0;
      end else if (mot_rise) begin
         mot_q <= FDDI_MOT_ON;
         mot_cnt_q <= MW'(MOTOR_TICKS);
      end else begin
         if (tick_q && mot_cnt_q != '0) begin
            mot_cnt_q <= mot_cnt_q - 1'b1;
         end
         case (mot_q)
            FDDI_MOT_OFF: mot_q <= FDDI_MOT_OFF;
            FDDI_MOT_ON: begin
               if (!host_s_q.motor_on) begin
                  mot_q <= FDDI_MOT_HOLD;
               end
            end
            FDDI_MOT_HOLD: begin
               // stop only when command gone and period spent
               if (mot_cnt_q == '0) begin
                  mot_q <= FDDI_MOT_OFF;
               end
            end
            default: mot_q <= FDDI_MOT_OFF;
         endcase
      end
   end

   // status derived from sensors
   logic ready_d;
   assign ready_d = sense_s_q.power_ok & sense_s_q.door_closed
                    & sense_s_q.speed_ok;
   logic motor_run_d;
   assign motor_run_d = (mot_q != FDDI_MOT_OFF);

   // door lock and busy request, sampled at select leading edge
   logic unlock_req;
   logic busy_req;
   logic unlock_lat_q;
   logic busy_lat_q;
   assign unlock_req = ~host_s_q.door_unlock_n;
   assign busy_req = ~host_s_q.in_use_n;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         unlock_lat_q <= 1'b0;
         busy_lat_q <= 1'b0;
      end else if (sel_rise) begin
         unlock_lat_q <= unlock_req;
         busy_lat_q <= busy_req;
      end
   end

   logic unlock_eff;
   logic busy_eff;
   always_comb begin
      case (door_mode)
         FDDI_DOOR_IFACE: begin
            unlock_eff = unlock_req;
            busy_eff = busy_req;
         end
         FDDI_DOOR_IFSEL: begin
            unlock_eff = unlock_req & sel;
            busy_eff = busy_req & sel;
         end
         FDDI_DOOR_LATCH: begin
            unlock_eff = unlock_lat_q;
            busy_eff = busy_lat_q;
         end
         default: begin
            unlock_eff = 1'b0;
            busy_eff = 1'b0;
         end
      endcase
   end

   // head load strap combination
   logic hl_d;
   assign hl_d = (~ctrl_q[FDDI_CTRL_HL_IFACE] | host_s_q.head_load)
      & (~ctrl_q[FDDI_CTRL_HL_SEL] | sel)
      & (ctrl_q[FDDI_CTRL_HL_MOTOR] ?
         (motor_run_d & sense_s_q.door_closed) : ready_d);

   // write path; protect blocks write and erase current
   logic wprot;
   logic wr_ok;
   assign wprot = sense_s_q.notch_covered;
   assign wr_ok = host_s_q.write_gate & ~wprot;
   logic wd_rise;
   assign wd_rise = rise(host_s_q.write_data, host_p_q.write_data);

   // disk-change flag; the set wins over a deselect in the same cycle
   logic dchg_q;
   logic removed;
   assign removed = rise(sense_p_q.disk_present, sense_s_q.disk_present);
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dchg_q <= 1'b0;
      end else if (removed && !sel) begin
         dchg_q <= 1'b1;
      end else if (sel_fall) begin
         dchg_q <= 1'b0;
      end
   end

   // read pulse stretcher, only while the read path is enabled
   logic [RW-1:0] rd_cnt_q;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rd_cnt_q <= '0;
      end else if (!host_s_q.write_gate
                   && rise(sense_s_q.flux_detect, sense_p_q.flux_detect)
                   && rd_cnt_q == '0) begin
         rd_cnt_q <= RW'(READ_CYC);
      end else if (rd_cnt_q != '0) begin
         rd_cnt_q <= rd_cnt_q - 1'b1;
      end
   end

   // index pulse stretcher in ticks; a new hole mid-pulse is ignored
   logic [IW-1:0] idx_cnt_q;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         idx_cnt_q <= '0;
      end else if (rise(sense_s_q.index_hole, sense_p_q.index_hole)
                   && idx_cnt_q == '0) begin
         idx_cnt_q <= IW'(INDEX_TICKS);
      end else if (tick_q && idx_cnt_q != '0) begin
         idx_cnt_q <= idx_cnt_q - 1'b1;
      end
   end

   // output flops toward the controller
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         stat_out <= '0;
      end else begin
         stat_out.ready <= ready_d;
         stat_out.track_zero_status <= sense_s_q.cyl_zero
                                       & sense_s_q.phase_a;
         stat_out.index <= (idx_cnt_q != '0);
         stat_out.read_data <= (rd_cnt_q != '0);
         stat_out.write_protect <= wprot & sel;
         stat_out.disk_change <= dchg_q & sel;
      end
   end

   // output flops toward drive mechanics
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         act_out <= '0;
      end else begin
         act_out.motor_run <= motor_run_d;
         act_out.head_load <= hl_d;
         act_out.write_en <= wr_ok;
         act_out.erase_en <= wr_ok;
         act_out.read_en <= ~host_s_q.write_gate;
         if (wr_ok && wd_rise) begin
            act_out.flux_write <= ~act_out.flux_write;
         end
         act_out.front_led <= unlock_eff | busy_eff;
         act_out.unlock_sol <= unlock_eff;
         act_out.lock_engage <= busy_eff & ~unlock_eff
                                & ctrl_q[FDDI_CTRL_LOCK_FIT];
      end
   end

   // read data only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            FDDI_ADDR_CTRL: reg_rdata <= {26'h0, ctrl_q};
            FDDI_ADDR_STAT: reg_rdata <= {24'h0, mot_q, dchg_q,
               stat_out.write_protect, stat_out.index,
               stat_out.track_zero_status, act_out.motor_run,
               stat_out.ready};
            default: reg_rdata <= 32'h0;
         endcase
      end else begin
         reg_rdata <= 32'h0;
      end
   end

   // checks on motor, status and write path
   chk_flux_edge: assert property (
      @(posedge clk_sys) disable iff (reset)
      $changed(act_out.flux_write) |-> $past(wr_ok) && $past(wd_rise))
      else $error("flux transition without write edge");
   chk_motor_restart: assert property (
      @(posedge clk_sys) disable iff (reset)
      mot_rise |=> mot_q == FDDI_MOT_ON && mot_cnt_q == MW'(MOTOR_TICKS))
      else $error("motor period not restarted");
   chk_motor_hold: assert property (
      @(posedge clk_sys) disable iff (reset)
      mot_q != FDDI_MOT_OFF && mot_cnt_q != '0 |=> mot_q != FDDI_MOT_OFF)
      else $error("motor stopped before period end");
   chk_ready_cause: assert property (
      @(posedge clk_sys) disable iff (reset)
      stat_out.ready |-> $past(sense_s_q.power_ok)
         && $past(sense_s_q.door_closed) && $past(sense_s_q.speed_ok))
      else $error("ready without its conditions");
   chk_read_width: assert property (
      @(posedge clk_sys) disable iff (reset)
      $rose(stat_out.read_data) |-> stat_out.read_data[*8])
      else $error("read pulse too short");
   chk_track_zero: assert property (
      @(posedge clk_sys) disable iff (reset)
      stat_out.track_zero_status |-> $past(sense_s_q.phase_a))
      else $error("track zero without phase");
   chk_track_cyl: assert property (
      @(posedge clk_sys) disable iff (reset)
      stat_out.track_zero_status |-> $past(sense_s_q.cyl_zero))
      else $error("track zero off cylinder zero");
   chk_wprot_gate: assert property (
      @(posedge clk_sys) disable iff (reset)
      $past(wprot) |-> !act_out.write_en && !act_out.erase_en)
      else $error("write current while protected");
   chk_wd_gate: assert property (
      @(posedge clk_sys) disable iff (reset)
      sense_s_q.notch_covered |=> $stable(act_out.flux_write))
      else $error("flux written while protected");
   chk_wprot_sel: assert property (
      @(posedge clk_sys) disable iff (reset)
      stat_out.write_protect |-> $past(sel))
      else $error("write protect shown unselected");
   chk_dchg_clear: assert property (
      @(posedge clk_sys) disable iff (reset)
      sel_fall && !removed |=> !dchg_q)
      else $error("disk change not cleared");
   chk_dchg_set: assert property (
      @(posedge clk_sys) disable iff (reset)
      removed && !sel |=> dchg_q)
      else $error("disk change not set");

   // checks on door, head load and pulse stretchers
   chk_door_sel: assert property (
      @(posedge clk_sys) disable iff (reset)
      door_mode == FDDI_DOOR_IFSEL && !sel |=> !act_out.unlock_sol)
      else $error("unlock while unselected");
   chk_unlock_led: assert property (
      @(posedge clk_sys) disable iff (reset)
      door_mode == FDDI_DOOR_IFACE && !host_s_q.door_unlock_n
         |=> act_out.front_led && act_out.unlock_sol)
      else $error("unlock request not acted on");
   chk_lock_fit: assert property (
      @(posedge clk_sys) disable iff (reset)
      !ctrl_q[FDDI_CTRL_LOCK_FIT] |=> !act_out.lock_engage)
      else $error("lock engaged with no lock fitted");
   chk_latch_hold: assert property (
      @(posedge clk_sys) disable iff (reset)
      !sel_rise |=> $stable(unlock_lat_q) && $stable(busy_lat_q))
      else $error("door latch moved without select edge");
   chk_head_sel: assert property (
      @(posedge clk_sys) disable iff (reset)
      ctrl_q[FDDI_CTRL_HL_SEL] && !sel |=> !act_out.head_load)
      else $error("head loaded while unselected");
   chk_read_gate: assert property (
      @(posedge clk_sys) disable iff (reset)
      host_s_q.write_gate && rd_cnt_q == '0 |=> rd_cnt_q == '0)
      else $error("read pulse during write");
   // holds only while (INDEX_TICKS-1)*TICK_CYC is at least 7 cycles
   chk_index_width: assert property (
      @(posedge clk_sys) disable iff (reset)
      $rose(stat_out.index) |-> stat_out.index[*8])
      else $error("index pulse too short");
endmodule

//--- tb/fddi_ctl_model.sv
`timescale 1ns/10ps
module fddi_ctl_model #(
   parameter int PULSE_CYC = 25,
   parameter int SETTLE_CYC = 20
) (
   input wire logic clk_sys,
   input wire logic motor_on,
   input wire logic wr_req,
   output logic write_data,
   output logic busy
);
   int run_q = 0;
   int cnt_q = 0;
   // spin-up wait; write requests before it ends are dropped
   always @(posedge clk_sys) begin
      if (!motor_on) begin
         run_q <= 0;
      end else if (run_q < SETTLE_CYC) begin
         run_q <= run_q + 1;
      end
   end
   // one bit: high, then equally long low so the next edge is clean
   always @(posedge clk_sys) begin
      if (cnt_q != 0) begin
         cnt_q <= cnt_q - 1;
      end else if (wr_req && run_q == SETTLE_CYC) begin
         cnt_q <= 2 * PULSE_CYC;
      end
   end
   assign write_data = cnt_q > PULSE_CYC;
   assign busy = cnt_q != 0;
endmodule

//--- tb/tb_flexible_disk_drive_interface.sv
`timescale 1ns/10ps
module tb_flexible_disk_drive_interface;
   import fddi_pkg::*;
   localparam int TICK = 10;
   localparam int RCYC = 100;
   localparam int ICYC = 35 * TICK;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   fddi_host_s host_v;
   fddi_host_s host_w;
   fddi_sense_s sense_v;
   fddi_stat_s stat_out;
   fddi_act_s act_out;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic wd;
   logic wr_req = 1'b0;
   logic busy;
   logic fw_last = 1'b0;
   logic [1:0] pul;
   logic [31:0] rnd = 32'heeee;
   int n_flux = 0;
   int fails = 0;
   int n_tests = 0;
   always #5 clk_sys = ~clk_sys;
   // write data line belongs to the controller model
   always_comb begin
      host_w = host_v;
      host_w.write_data = wd;
   end
   assign pul = {stat_out.index, stat_out.read_data};
   fddi_drive #(.TICK_CYC(TICK), .MOTOR_TICKS(50), .INDEX_TICKS(35),
      .READ_CYC(RCYC)) dut_u (.clk_sys(clk_sys), .reset(reset),
      .host_in(host_w), .sense_in(sense_v), .stat_out(stat_out),
      .act_out(act_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   fddi_ctl_model #(.PULSE_CYC(25), .SETTLE_CYC(20)) ctl_u (
      .clk_sys(clk_sys), .motor_on(host_v.motor_on), .wr_req(wr_req),
      .write_data(wd), .busy(busy));
   // count flux toggles, not levels, so a falling edge would show up
   always @(posedge clk_sys) begin
      fw_last <= act_out.flux_write;
      if (!reset && act_out.flux_write !== fw_last) n_flux <= n_flux + 1;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // waits rising edges; a read here sees the value of the cycle before,
   // and inputs driven here by non-blocking assignment follow the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      tick(1);
      d = reg_rdata;
   endtask
   task automatic send_bit();
      int k;
      k = 0;
      @(posedge clk_sys);
      wr_req <= 1'b1;
      @(posedge clk_sys);
      wr_req <= 1'b0;
      tick(1);
      while (busy === 1'b1 && k < 100) begin
         tick(1);
         k++;
      end
   endtask
   // bounded wait for the pulse, then its length in cycles
   task automatic width(input int s, output int w);
      int k;
      w = 0;
      k = 0;
      while (pul[s] !== 1'b1 && k < 20) begin
         tick(1);
         k++;
      end
      while (pul[s] === 1'b1 && w < 1000) begin
         tick(1);
         w++;
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      report_and_stop();
   end
   initial begin
      logic [31:0] d;
      int w;
      int f0;
      logic r;
      host_v = 7'h03;
      sense_v = '0;
      sense_v.disk_present = 1'b1;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      tick(1);
      check(stat_out, 0);
      check(act_out, 0);
      rd(FDDI_ADDR_CTRL, d);
      check(d, 0);
      rnd = lfsr(rnd);
      wr(FDDI_ADDR_CTRL, {26'h0, rnd[5:0]});
      rd(FDDI_ADDR_CTRL, d);
      check(d, {26'h0, rnd[5:0]});
      rd(4'hc, d);
      check(d, 0);
      $display("reset and registers done");
      // random sensor and strap mixes, motor left off
      for (int i = 0; i < 24; i++) begin
         rnd = lfsr(rnd);
         wr(FDDI_ADDR_CTRL, {29'h0, rnd[2:0]});
         sense_v.power_ok <= rnd[3];
         sense_v.door_closed <= rnd[4];
         sense_v.speed_ok <= rnd[5];
         sense_v.cyl_zero <= rnd[6];
         sense_v.phase_a <= rnd[7];
         sense_v.notch_covered <= rnd[8];
         host_v.unit_sel <= rnd[9];
         host_v.head_load <= rnd[10];
         tick(6);
         r = rnd[3] & rnd[4] & rnd[5];
         check(stat_out.ready, r);
         check(stat_out.track_zero_status, rnd[6] & rnd[7]);
         check(stat_out.write_protect, rnd[8] & rnd[9]);
         check(act_out.head_load, (!rnd[0] | rnd[10]) & (!rnd[1] | rnd[9])
            & (!rnd[2] & r));
         check(stat_out.disk_change, 1'b0);
      end
      $display("status mix done");
      wr(FDDI_ADDR_CTRL, 32'h0);
      sense_v.notch_covered <= 1'b0;
      host_v <= 7'h7b; // selected, motor on, head load, write gate
      tick(30);
      check({act_out.write_en, act_out.erase_en, act_out.read_en},
         3'h6);
      f0 = n_flux;
      repeat (5) send_bit();
      tick(6);
      check(n_flux - f0, 5);
      sense_v.flux_detect <= 1'b1;
      width(0, w);
      check(w, 0);
      sense_v.notch_covered <= 1'b1;
      sense_v.flux_detect <= 1'b0;
      tick(6);
      check({act_out.write_en, act_out.erase_en}, 2'h0);
      check(stat_out.write_protect, 1'b1);
      repeat (2) send_bit();
      tick(6);
      check(n_flux - f0, 5);
      $display("write path done");
      sense_v.notch_covered <= 1'b0;
      host_v.write_gate <= 1'b0;
      tick(6);
      check({act_out.write_en, act_out.read_en}, 2'h1);
      repeat (3) begin
         sense_v.flux_detect <= 1'b1;
         width(0, w);
         check(w >= RCYC - 1 && w <= RCYC + 1, 1);
         sense_v.flux_detect <= 1'b0;
         tick(4);
      end
      sense_v.index_hole <= 1'b1;
      width(1, w);
      check(w >= ICYC - TICK && w <= ICYC + TICK, 1);
      sense_v.index_hole <= 1'b0;
      $display("read and index done");
      host_v.motor_on <= 1'b0;
      tick(700);
      check(act_out.motor_run, 1'b0);
      host_v.motor_on <= 1'b1;
      tick(5);
      check(act_out.motor_run, 1'b1);
      host_v.motor_on <= 1'b0;
      tick(300);
      host_v.motor_on <= 1'b1;
      tick(2);
      host_v.motor_on <= 1'b0;
      tick(420);
      check(act_out.motor_run, 1'b1);
      tick(150);
      check(act_out.motor_run, 1'b0);
      $display("motor timer done");
      host_v.unit_sel <= 1'b0;
      wr(FDDI_ADDR_CTRL, 32'h20);
      host_v.in_use_n <= 1'b0;
      tick(6);
      check({act_out.front_led, act_out.lock_engage}, 2'h3);
      host_v.in_use_n <= 1'b1;
      host_v.door_unlock_n <= 1'b0;
      tick(6);
      check({act_out.front_led, act_out.unlock_sol}, 2'h3);
      wr(FDDI_ADDR_CTRL, 32'h28);
      tick(6);
      check(act_out.unlock_sol, 1'b0);
      host_v.unit_sel <= 1'b1;
      tick(6);
      check(act_out.unlock_sol, 1'b1);
      host_v.unit_sel <= 1'b0;
      wr(FDDI_ADDR_CTRL, 32'h30);
      host_v.unit_sel <= 1'b1;
      tick(6);
      host_v.door_unlock_n <= 1'b1;
      tick(6);
      check(act_out.unlock_sol, 1'b1);
      host_v.unit_sel <= 1'b0;
      tick(6);
      host_v.unit_sel <= 1'b1;
      tick(6);
      check(act_out.unlock_sol, 1'b0);
      $display("door options done");
      sense_v.disk_present <= 1'b0;
      tick(6);
      check(stat_out.disk_change, 1'b0);
      host_v.unit_sel <= 1'b0;
      sense_v.disk_present <= 1'b1;
      tick(6);
      check(stat_out.disk_change, 1'b0);
      // removal while deselected is what sets the flag
      sense_v.disk_present <= 1'b0;
      tick(6);
      rd(FDDI_ADDR_STAT, d);
      check(d[5], 1'b1);
      host_v.unit_sel <= 1'b1;
      tick(6);
      check(stat_out.disk_change, 1'b1);
      host_v.unit_sel <= 1'b0;
      tick(6);
      host_v.unit_sel <= 1'b1;
      tick(6);
      check(stat_out.disk_change, 1'b0);
      $display("disk change done");
      report_and_stop();
   end
endmodule
